// ---- shlp_consts.vh ----
// Constants for the shut height limit and position output block
`ifndef SHLP_CONSTS_VH
`define SHLP_CONSTS_VH

// Position in thousandths of an inch, 0 .. 999.999 in
`define SHLP_POS_W 20
`define SHLP_POS_MAX 20'hF423F
`define SHLP_LIM_LO_RST 20'h00000
`define SHLP_LIM_HI_RST 20'hF423F

// Parallel word: six BCD digits is the widest format
`define SHLP_PAR_W 24

// Override code 2110
`define SHLP_OVR_CODE 16'h083E

// Analog endpoints: millivolts or microamps, signed 16 bit
`define SHLP_AV_MIN 16'hD8F0
`define SHLP_AV_MAX 16'h2710
`define SHLP_AI_MIN 16'h0000
`define SHLP_AI_MAX 16'h4E20

// Analog register index = setting suffix; byte address = index * 4
`define SHLP_CH_STRIDE 6
`define SHLP_CH_MINP 2
`define SHLP_CH_MAXP 3
`define SHLP_CH_TYPE 4
`define SHLP_CH_MINV 5
`define SHLP_CH_MAXV 6
`define SHLP_IDX_LAST 8'h0C

// Other register byte addresses
`define SHLP_ADDR_CTRL 8'h40
`define SHLP_ADDR_LIM_LO 8'h44
`define SHLP_ADDR_LIM_HI 8'h48
`define SHLP_ADDR_OVR 8'h4C
`define SHLP_ADDR_STAT 8'h50
`define SHLP_ADDR_POS 8'h54
`define SHLP_ADDR_AOUT1 8'h58
`define SHLP_ADDR_AOUT2 8'h5C
`define SHLP_ADDR_SLOT 8'h60

// Control register fields
`define SHLP_C_RPOL 0
`define SHLP_C_FMT_LO 1
`define SHLP_C_FMT_HI 2
`define SHLP_C_HS 3
`define SHLP_C_LVL 4
`define SHLP_C_ERR_LO 5
`define SHLP_C_ERR_HI 6
`define SHLP_CTRL_RST 7'h10

// Code formats and error-state choices
`define SHLP_FMT_BIN 2'h0
`define SHLP_FMT_BCD 2'h1
`define SHLP_FMT_GRAY 2'h2
`define SHLP_ERR_OFF 2'h0
`define SHLP_ERR_ON 2'h1
`define SHLP_ERR_HOLD 2'h2

`endif

// ---- shlp_plc_model.sv ----
// Behavioural PLC input card reading the parallel port
`timescale 1ns/10ps
module shlp_plc_model (
  input wire run,
  input wire hold,
  input wire [23:0] par_out,
  output logic sync_pin,
  output logic latch_pin,
  output logic [23:0] seen
);
  assign latch_pin = hold;
  // square wave, parked low between frames
  initial begin
    sync_pin = 1'h0;
    seen = 24'h0;
    #3.1;
    forever begin
      #62.5;
      if (run || sync_pin) sync_pin = ~sync_pin;
      // Read mid-period, well clear of the update
      if (run && !sync_pin) seen = par_out;
    end
  end
endmodule // shlp_plc_model

// ---- shlp_sva.sv ----
// Checker for limit relays, override and parallel port timing
`timescale 1ns/10ps
`include "shlp_consts.vh"
module shlp_sva (
  input wire sys_clk,
  input wire nrst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  input wire [`SHLP_POS_W-1:0] pos_in,
  input wire pos_fault,
  input wire sync_pin,
  input wire latch_pin,
  input wire [`SHLP_PAR_W-1:0] par_out,
  input wire relay_lo,
  input wire relay_hi,
  input wire led_lo,
  input wire led_hi
);
  logic [6:0] ctl_r; // Shadow control
  logic [19:0] lo_r; // Shadow lower limit
  logic [19:0] hi_r; // Shadow upper limit
  logic [19:0] mn_r; // Lowest position since trip fell
  logic [2:0] live_r; // Cycles since reset, saturating
  logic [2:0] wq_r; // Cycles since any write
  logic [2:0] age_r; // Cycles since sync rise
  logic sy_r; // Last sync sample
  logic lf_r; // Last lower trip sample
  wire wr = psel & penable & pwrite; // Write strobe
  // Clamp mirrors the limit write clamp
  wire [19:0] lim = (pwdata > 32'h000F423F) ? `SHLP_POS_MAX : pwdata[19:0];
  // Mirror writes; internal reset lags nrst, hence live_r
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      ctl_r <= `SHLP_CTRL_RST;
      lo_r <= `SHLP_LIM_LO_RST;
      hi_r <= `SHLP_LIM_HI_RST;
      mn_r <= `SHLP_POS_MAX;
      live_r <= 3'h0;
      wq_r <= 3'h0;
      age_r <= 3'h7;
      sy_r <= 1'h0;
      lf_r <= 1'h0;
    end else begin
      live_r <= (live_r == 3'h7) ? live_r : live_r + 3'h1;
      wq_r <= wr ? 3'h0 : (wq_r == 3'h7) ? wq_r : wq_r + 3'h1;
      sy_r <= sync_pin;
      age_r <= (sync_pin && !sy_r) ? 3'h0 : (age_r == 3'h7) ? age_r : age_r + 3'h1;
      lf_r <= led_lo;
      mn_r <= ((lf_r && !led_lo) || pos_in < mn_r) ? pos_in : mn_r;
      if (wr && paddr == `SHLP_ADDR_CTRL) ctl_r <= pwdata[6:0];
      if (wr && paddr == `SHLP_ADDR_LIM_LO) lo_r <= lim;
      if (wr && paddr == `SHLP_ADDR_LIM_HI) hi_r <= lim;
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  wire live = live_r == 3'h7; // Past internal reset
  wire calm = live && wq_r == 3'h7; // No recent write
  property p_lo;
    (live && pos_in > lo_r) ##1 (pos_in <= lo_r) |=> led_lo;
  endproperty
  a_lo: assert property (p_lo) else $error("lower trip missing");
  property p_hi;
    (live && pos_in < hi_r) ##1 (pos_in >= hi_r) |=> led_hi;
  endproperty
  a_hi: assert property (p_hi) else $error("upper trip missing");
  property p_rel0;
    live && !ctl_r[0] |-> relay_lo == !(led_lo | pos_fault) && relay_hi == !(led_hi | pos_fault);
  endproperty
  a_rel0: assert property (p_rel0) else $error("relay state wrong, polarity 0");
  property p_rel1;
    live && ctl_r[0] |-> relay_lo == (led_lo | pos_fault) && relay_hi == (led_hi | pos_fault);
  endproperty
  a_rel1: assert property (p_rel1) else $error("relay state wrong, polarity 1");
  property p_ovr;
    (live && wr && paddr == `SHLP_ADDR_OVR && pwdata == 32'h0000083E && led_lo) ##1 $stable(pos_in)[*3] |-> !led_lo;
  endproperty
  a_ovr: assert property (p_ovr) else $error("override did not clear trip");
  property p_re;
    live && !led_lo && !lf_r && pos_in < mn_r && pos_in <= lo_r |=> led_lo;
  endproperty
  a_re: assert property (p_re) else $error("no trip after override");
  property p_sync;
    calm && ctl_r[3] && par_out != $past(par_out) |-> age_r >= 3'h1 && age_r <= 3'h5;
  endproperty
  a_sync: assert property (p_sync) else $error("update without sync edge");
  property p_frz;
    (calm && !ctl_r[3] && !pos_fault && latch_pin)[*4] |=> $stable(par_out);
  endproperty
  a_frz: assert property (p_frz) else $error("port moved while latched");
  property p_trk;
    (calm && ctl_r[4:1] == 4'h8 && !latch_pin && !pos_fault && $stable(pos_in))[*5] |-> par_out == {4'h0, pos_in};
  endproperty
  a_trk: assert property (p_trk) else $error("port not tracking position");
  c_trip: cover property (led_lo ##1 !led_lo);
  c_sync: cover property (ctl_r[3] && $changed(par_out));
  c_frz: cover property (latch_pin && $changed(pos_in));
endmodule // shlp_sva
bind shlp_top shlp_sva u_sva (.sys_clk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .pos_in, .pos_fault,
  .sync_pin, .latch_pin, .par_out, .relay_lo, .relay_hi, .led_lo, .led_hi);

// ---- shlp_top.v ----
// Shut height limit relays, parallel position port and analog scaling
//
// The APB register port and the placing of the registers were decided locally.
`timescale 1ns/10ps
`include "shlp_consts.vh"

// How it works
// - At or below lower limit, trip lower relay
// - Lower limit resets zero, clamps to 999.999
// - Polarity 0: energized normally, drop on fault
// - Polarity 1: de-energized normally, energize on fault
// - Code 2110 on override re-closes tripped relays
// - Moving further toward limit trips again
// - Output format 0 binary, 1 BCD, 2 Gray
// - Handshake 0 latch, 1 synchronize
// - Synchronize mode updates only on sync edge
// - No sync square wave, no refresh
// - Latch mode: track while low, freeze high
// - Logic level 0 active low, 1 active high
// - On input failure: off, on, or hold
// - Per-channel type: 0 voltage, 1 current
// - Linear scaling between endpoints, clamped outside
// - Endpoint values clamped to type range
// - Slot digit prefix; ch1 suffixes 04/02/05/03/06
// - Ch2 suffixes 10/08/11/09/12
// - At or above upper limit, trip upper relay
module shlp_top #(
  parameter SLOT_DIGIT = 4'h2
) (
  input wire sys_clk,
  input wire nrst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire [`SHLP_POS_W-1:0] pos_in,
  input wire pos_fault,
  input wire sync_pin,
  input wire latch_pin,
  output wire [`SHLP_PAR_W-1:0] par_out,
  output wire relay_lo,
  output wire relay_hi,
  output wire led_lo,
  output wire led_hi,
  output wire [15:0] ana_val_ch1,
  output wire [15:0] ana_val_ch2,
  output wire ana_cur_ch1,
  output wire ana_cur_ch2
);

  // Reset release through two flops
  reg rst_m_r;
  reg rst_n_r;
  // Pin synchronisers, first stage read only by second
  reg sync_m_r, sync_s_r, sync_d_r;
  reg latch_m_r, latch_s_r;
  // Settings
  reg [6:0] ctrl_r;
  reg [`SHLP_POS_W-1:0] lim_lo_r;
  reg [`SHLP_POS_W-1:0] lim_hi_r;
  // Trip and override state
  reg trip_lo_r, trip_hi_r;
  reg ovr_lo_r, ovr_hi_r;
  reg [`SHLP_POS_W-1:0] ovr_lo_pos_r;
  reg [`SHLP_POS_W-1:0] ovr_hi_pos_r;
  reg ovr_req_r;
  // Parallel port state
  reg [`SHLP_POS_W-1:0] last_pos_r;
  reg [`SHLP_PAR_W-1:0] par_r;
  // Bus answer registers
  reg [31:0] rdata_r;
  reg err_r;
  // Analog settings and outputs per channel
  reg ch_type_r [0:1];
  reg [`SHLP_POS_W-1:0] ch_minp_r [0:1];
  reg [`SHLP_POS_W-1:0] ch_maxp_r [0:1];
  reg [15:0] ch_minv_r [0:1];
  reg [15:0] ch_maxv_r [0:1];
  reg [15:0] ch_out_r [0:1];

  // Setup/access decode
  wire setup = psel & ~penable;
  wire wr_acc = psel & penable & pwrite;
  wire rd_only = setup & ~pwrite;

  // Control fields
  wire rpol = ctrl_r[`SHLP_C_RPOL];
  wire [1:0] fmt = ctrl_r[`SHLP_C_FMT_HI:`SHLP_C_FMT_LO];
  wire hs_sync = ctrl_r[`SHLP_C_HS];
  wire lvl_high = ctrl_r[`SHLP_C_LVL];
  wire [1:0] err_mode = ctrl_r[`SHLP_C_ERR_HI:`SHLP_C_ERR_LO];

  // Clamp a written position to the documented span
  function [`SHLP_POS_W-1:0] pos_clamp;
    input [31:0] v;
    begin
      if (v > {12'h000, `SHLP_POS_MAX})
        pos_clamp = `SHLP_POS_MAX;
      else
        pos_clamp = v[`SHLP_POS_W-1:0];
    end
  endfunction

  // Clamp an endpoint value to voltage or current span
  function [15:0] val_clamp;
    input [15:0] v;
    input cur;
    reg signed [15:0] s;
    begin
      s = v;
      if (cur) begin
        if (s < $signed(`SHLP_AI_MIN))
          val_clamp = `SHLP_AI_MIN;
        else if (s > $signed(`SHLP_AI_MAX))
          val_clamp = `SHLP_AI_MAX;
        else
          val_clamp = v;
      end else begin
        if (s < $signed(`SHLP_AV_MIN))
          val_clamp = `SHLP_AV_MIN;
        else if (s > $signed(`SHLP_AV_MAX))
          val_clamp = `SHLP_AV_MAX;
        else
          val_clamp = v;
      end
    end
  endfunction

  // Binary to six BCD digits, shift-and-add-3
  function [`SHLP_PAR_W-1:0] to_bcd;
    input [`SHLP_POS_W-1:0] b;
    reg [`SHLP_PAR_W-1:0] d;
    integer i, k;
    begin
      d = {`SHLP_PAR_W{1'b0}};
      for (i = `SHLP_POS_W - 1; i >= 0; i = i - 1) begin
        for (k = 0; k < 6; k = k + 1) begin
          if (d[k*4 +: 4] > 4'h4)
            d[k*4 +: 4] = d[k*4 +: 4] + 4'h3;
        end
        d = {d[`SHLP_PAR_W-2:0], b[i]};
      end
      to_bcd = d;
    end
  endfunction

  // Reset synchroniser, async assert, clocked release
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rst_m_r <= 1'b0;
      rst_n_r <= 1'b0;
    end else begin
      rst_m_r <= 1'b1;
      rst_n_r <= rst_m_r;
    end
  end

  // Pin synchronisers and sync edge history
  always @(posedge sys_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      sync_m_r <= 1'b0;
      sync_s_r <= 1'b0;
      sync_d_r <= 1'b0;
      latch_m_r <= 1'b0;
      latch_s_r <= 1'b0;
    end else begin
      sync_m_r <= sync_pin;
      sync_s_r <= sync_m_r;
      sync_d_r <= sync_s_r;
      latch_m_r <= latch_pin;
      latch_s_r <= latch_m_r;
    end
  end

  // Address decode for analog block
  wire [5:0] widx = paddr[7:2];
  wire amap = (paddr[1:0] == 2'b00) && (paddr[7:6] == 2'b00) && (widx >= 6'h02) && (widx <= 6'h0C)
              && (widx != 6'h07);

  // Settings registers and override request
  always @(posedge sys_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      ctrl_r <= `SHLP_CTRL_RST;
      lim_lo_r <= `SHLP_LIM_LO_RST;
      lim_hi_r <= `SHLP_LIM_HI_RST;
      ovr_req_r <= 1'b0;
    end else begin
      ovr_req_r <= 1'b0;
      if (wr_acc) begin
        case (paddr)
          `SHLP_ADDR_CTRL: ctrl_r <= pwdata[6:0];
          `SHLP_ADDR_LIM_LO: lim_lo_r <= pos_clamp(pwdata);
          `SHLP_ADDR_LIM_HI: lim_hi_r <= pos_clamp(pwdata);
          `SHLP_ADDR_OVR: ovr_req_r <= (pwdata[15:0] == `SHLP_OVR_CODE);
          default: ovr_req_r <= 1'b0;
        endcase
      end
    end
  end

  // Limit comparisons
  wire at_lo = (pos_in <= lim_lo_r);
  wire at_hi = (pos_in >= lim_hi_r);

  // Trip and override handling per limit
  always @(posedge sys_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      trip_lo_r <= 1'b0;
      trip_hi_r <= 1'b0;
      ovr_lo_r <= 1'b0;
      ovr_hi_r <= 1'b0;
      ovr_lo_pos_r <= {`SHLP_POS_W{1'b0}};
      ovr_hi_pos_r <= {`SHLP_POS_W{1'b0}};
    end else begin
      // override remembers where it was granted
      if (ovr_req_r && trip_lo_r) begin
        ovr_lo_r <= 1'b1;
        ovr_lo_pos_r <= pos_in;
        trip_lo_r <= 1'b0;
      end else if (!at_lo) begin
        // Back inside range: override no longer needed
        ovr_lo_r <= 1'b0;
        trip_lo_r <= 1'b0;
      end else if (!ovr_lo_r || pos_in < ovr_lo_pos_r) begin
        // trip at or below lower limit
        trip_lo_r <= 1'b1;
        ovr_lo_r <= 1'b0;
      end
      if (ovr_req_r && trip_hi_r) begin
        ovr_hi_r <= 1'b1;
        ovr_hi_pos_r <= pos_in;
        trip_hi_r <= 1'b0;
      end else if (!at_hi) begin
        ovr_hi_r <= 1'b0;
        trip_hi_r <= 1'b0;
      end else if (!ovr_hi_r || pos_in > ovr_hi_pos_r) begin
        // trip at or above upper limit
        trip_hi_r <= 1'b1;
        ovr_hi_r <= 1'b0;
      end
    end
  end

  // Relay drive; a fault trips both relays in either polarity, regardless of override
  wire flt_lo = trip_lo_r | pos_fault;
  wire flt_hi = trip_hi_r | pos_fault;
  assign relay_lo = rpol ? flt_lo : ~flt_lo;
  assign relay_hi = rpol ? flt_hi : ~flt_hi;
  assign led_lo = trip_lo_r;
  assign led_hi = trip_hi_r;

  // Encoded word of the last valid position
  reg [`SHLP_PAR_W-1:0] code_w;
  always @* begin
    case (fmt)
      `SHLP_FMT_BCD: code_w = to_bcd(last_pos_r);
      `SHLP_FMT_GRAY: code_w = {4'h0, last_pos_r ^ (last_pos_r >> 1)};
      default: code_w = {4'h0, last_pos_r};
    endcase
  end

  // Error-state substitution, then logic level
  reg [`SHLP_PAR_W-1:0] word_w;
  always @* begin
    if (pos_fault && err_mode == `SHLP_ERR_OFF)
      word_w = {`SHLP_PAR_W{1'b0}};
    else if (pos_fault && err_mode == `SHLP_ERR_ON)
      word_w = {`SHLP_PAR_W{1'b1}};
    else
      word_w = code_w;
    if (!lvl_high)
      word_w = ~word_w;
  end

  // Update strobe: rising sync edge or transparent latch
  // sync mode waits for the edge
  wire sync_rise = sync_s_r & ~sync_d_r;
  // latch input high freezes the port
  wire par_upd = hs_sync ? sync_rise : ~latch_s_r;

  // Parallel port register; all bits move in one edge
  always @(posedge sys_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      last_pos_r <= {`SHLP_POS_W{1'b0}};
      par_r <= {`SHLP_PAR_W{1'b0}};
    end else begin
      // Failure keeps the last good reading for hold mode
      if (!pos_fault)
        last_pos_r <= pos_in;
      if (par_upd)
        par_r <= word_w;
    end
  end
  assign par_out = par_r;

  // Analog channels: settings, clamping, linear scaling
  genvar c;
  generate
    for (c = 0; c < 2; c = c + 1) begin : g_ch
      // channel 2 indices 8..12
      // Channel base index, cut to the index width on purpose
      wire [31:0] b_full = c * `SHLP_CH_STRIDE;
      wire [5:0] b = b_full[5:0];
      wire sel_p0 = wr_acc && amap && widx == b + `SHLP_CH_MINP;
      wire sel_p1 = wr_acc && amap && widx == b + `SHLP_CH_MAXP;
      wire sel_t = wr_acc && amap && widx == b + `SHLP_CH_TYPE;
      wire sel_v0 = wr_acc && amap && widx == b + `SHLP_CH_MINV;
      wire sel_v1 = wr_acc && amap && widx == b + `SHLP_CH_MAXV;
      // Scaling arithmetic, signed
      wire signed [21:0] dpos = $signed({2'b00, pos_in}) - $signed({2'b00, ch_minp_r[c]});
      wire signed [21:0] span = $signed({2'b00, ch_maxp_r[c]}) - $signed({2'b00, ch_minp_r[c]});
      wire signed [17:0] dval = $signed({{2{ch_maxv_r[c][15]}}, ch_maxv_r[c]})
                                - $signed({{2{ch_minv_r[c][15]}}, ch_minv_r[c]});
      wire signed [39:0] prod = dpos * dval;
      wire signed [39:0] quot = (span > 0) ? prod / span : 40'sh0000000000;
      wire [39:0] lin = $signed({{24{ch_minv_r[c][15]}}, ch_minv_r[c]}) + quot;

      // Channel settings; type change re-clamps stored endpoints
      always @(posedge sys_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
          ch_type_r[c] <= 1'b0;
          ch_minp_r[c] <= {`SHLP_POS_W{1'b0}};
          ch_maxp_r[c] <= `SHLP_POS_MAX;
          ch_minv_r[c] <= 16'h0000;
          ch_maxv_r[c] <= 16'h0000;
        end else begin
          if (sel_t) begin
            ch_type_r[c] <= pwdata[0];
            ch_minv_r[c] <= val_clamp(ch_minv_r[c], pwdata[0]);
            ch_maxv_r[c] <= val_clamp(ch_maxv_r[c], pwdata[0]);
          end
          if (sel_p0)
            ch_minp_r[c] <= pos_clamp(pwdata);
          if (sel_p1)
            ch_maxp_r[c] <= pos_clamp(pwdata);
          if (sel_v0)
            ch_minv_r[c] <= val_clamp(pwdata[15:0], ch_type_r[c]);
          if (sel_v1)
            ch_maxv_r[c] <= val_clamp(pwdata[15:0], ch_type_r[c]);
        end
      end

      // Output value, clamped to the endpoint outside the span
      always @(posedge sys_clk or negedge rst_n_r) begin
        if (!rst_n_r)
          ch_out_r[c] <= 16'h0000;
        else if (pos_in <= ch_minp_r[c])
          ch_out_r[c] <= ch_minv_r[c];
        else if (pos_in >= ch_maxp_r[c])
          ch_out_r[c] <= ch_maxv_r[c];
        else
          ch_out_r[c] <= lin[15:0];
      end
    end
  endgenerate

  assign ana_val_ch1 = ch_out_r[0];
  assign ana_val_ch2 = ch_out_r[1];
  assign ana_cur_ch1 = ch_type_r[0];
  assign ana_cur_ch2 = ch_type_r[1];

  // Read mux for analog block
  reg [31:0] ard_w;
  always @* begin
    ard_w = 32'h00000000;
    case (widx >= 6'h08 ? widx - 6'h06 : widx)
      6'h02: ard_w = {12'h000, ch_minp_r[widx >= 6'h08]};
      6'h03: ard_w = {12'h000, ch_maxp_r[widx >= 6'h08]};
      6'h04: ard_w = {31'h00000000, ch_type_r[widx >= 6'h08]};
      6'h05: ard_w = {{16{ch_minv_r[widx >= 6'h08][15]}}, ch_minv_r[widx >= 6'h08]};
      6'h06: ard_w = {{16{ch_maxv_r[widx >= 6'h08][15]}}, ch_maxv_r[widx >= 6'h08]};
      default: ard_w = 32'h00000000;
    endcase
  end

  // Full read mux and map check
  reg [31:0] rd_w;
  reg hit_w;
  always @* begin
    hit_w = 1'b1;
    rd_w = 32'h00000000;
    if (amap)
      rd_w = ard_w;
    else begin
      case (paddr)
        `SHLP_ADDR_CTRL: rd_w = {25'h0000000, ctrl_r};
        `SHLP_ADDR_LIM_LO: rd_w = {12'h000, lim_lo_r};
        `SHLP_ADDR_LIM_HI: rd_w = {12'h000, lim_hi_r};
        `SHLP_ADDR_OVR: rd_w = {30'h00000000, ovr_hi_r, ovr_lo_r};
        `SHLP_ADDR_STAT: rd_w = {25'h0000000, latch_s_r, sync_s_r, pos_fault, relay_hi, relay_lo,
                                 trip_hi_r, trip_lo_r};
        `SHLP_ADDR_POS: rd_w = {12'h000, last_pos_r};
        `SHLP_ADDR_AOUT1: rd_w = {{16{ch_out_r[0][15]}}, ch_out_r[0]};
        `SHLP_ADDR_AOUT2: rd_w = {{16{ch_out_r[1][15]}}, ch_out_r[1]};
        `SHLP_ADDR_SLOT: rd_w = {28'h0000000, SLOT_DIGIT[3:0]};
        default: hit_w = 1'b0;
      endcase
    end
  end

  // Bus answer captured in setup, shown in access
  always @(posedge sys_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      rdata_r <= 32'h00000000;
      err_r <= 1'b0;
    end else if (setup) begin
      rdata_r <= rd_only ? rd_w : 32'h00000000;
      err_r <= ~hit_w;
    end
  end

  // Zero-wait access phase; error only shown with ready
  assign pready = psel & penable;
  assign pslverr = psel & penable & err_r;
  assign prdata = rdata_r;

endmodule // shlp_top

// ---- test_shut_height_limit_and_position_output.sv ----
// Self-checking bench for the shut height block
`timescale 1ns/10ps
`include "shlp_consts.vh"
module test_shut_height_limit_and_position_output;
  logic sys_clk, nrst, psel, penable, pwrite, pos_fault, run, hold;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, er, sync_pin, latch_pin;
  logic relay_lo, relay_hi, led_lo, led_hi, ana_cur_ch1, ana_cur_ch2;
  logic [19:0] pos_in;
  logic [23:0] par_out, seen;
  logic [15:0] ana_val_ch1, ana_val_ch2;
  int miscompares, checked;
  wire [3:0] rl = {led_hi, relay_hi, led_lo, relay_lo}; // Relay view
  shlp_top #(.SLOT_DIGIT(4'h4)) uut (.sys_clk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .pos_in, .pos_fault, .sync_pin, .latch_pin, .par_out, .relay_lo, .relay_hi,
    .led_lo, .led_hi, .ana_val_ch1, .ana_val_ch2, .ana_cur_ch1, .ana_cur_ch2);
  shlp_plc_model plc (.run, .hold, .par_out, .sync_pin, .latch_pin, .seen);
  // Free-running system clock
  initial begin
    sys_clk = 1'h0;
    forever #4 sys_clk = ~sys_clk;
  end
  task automatic wrap_up;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  // One APB transfer; waits on pready, ends with an idle cycle
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    rd = prdata;
    er = pslverr;
    if (n >= 20) begin
      miscompares++;
      wrap_up();
    end
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge sys_clk);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    apb(1'h0, a, 32'h0);
    cmp(rd, e);
  endtask
  task automatic mv(input logic [19:0] p);
    pos_in <= p;
    cyc(4);
  endtask
  task automatic s_regs;
    rdc(`SHLP_ADDR_CTRL, 32'h10);
    rdc(`SHLP_ADDR_LIM_LO, 32'h0);
    rdc(`SHLP_ADDR_LIM_HI, 32'h000F423F);
    rdc(`SHLP_ADDR_SLOT, 32'h4);
    apb(1'h1, `SHLP_ADDR_LIM_LO, 32'h00FFFFFF);
    rdc(`SHLP_ADDR_LIM_LO, 32'h000F423F);
    rdc(8'h64, 32'h0);
    cmp({31'h0, er}, 32'h1);
    apb(1'h1, `SHLP_ADDR_LIM_LO, 32'h3E8);
    apb(1'h1, `SHLP_ADDR_LIM_HI, 32'h1388);
  endtask
  task automatic s_relay;
    mv(20'h00BB8);
    cmp(rl, 32'h5);
    mv(20'h003E8);
    cmp(rl, 32'h6);
    mv(20'h01388);
    cmp(rl, 32'h9);
    mv(20'h00BB8);
    apb(1'h1, `SHLP_ADDR_CTRL, 32'h11);
    cmp(rl, 32'h0);
    mv(20'h003E8);
    cmp(rl, 32'h3);
    mv(20'h00BB8);
    pos_fault <= 1'h1;
    cyc(2);
    cmp(rl, 32'h5);
    apb(1'h1, `SHLP_ADDR_CTRL, 32'h10);
    cmp(rl, 32'h0);
    pos_fault <= 1'h0;
  endtask
  task automatic s_ovr;
    mv(20'h00384);
    apb(1'h1, `SHLP_ADDR_OVR, 32'h083D);
    cyc(3);
    cmp(rl, 32'h6);
    apb(1'h1, `SHLP_ADDR_OVR, 32'h083E);
    cyc(3);
    cmp(rl, 32'h5);
    mv(20'h00383);
    cmp(rl, 32'h6);
    mv(20'h013EC);
    apb(1'h1, `SHLP_ADDR_OVR, 32'h083E);
    cyc(3);
    cmp(rl, 32'h5);
    mv(20'h013ED);
    cmp(rl, 32'h9);
  endtask
  // All formats at both levels
  task automatic s_fmt;
    logic [23:0] ex [3];
    ex[0] = 24'h01E240;
    ex[1] = 24'h123456;
    ex[2] = 24'h01E240 ^ (24'h01E240 >> 1);
    mv(20'h1E240);
    for (int f = 0; f < 6; f++) begin
      apb(1'h1, `SHLP_ADDR_CTRL, {27'h0, f >= 3, 1'h0, 2'(f % 3), 1'h0});
      cyc(8);
      cmp({8'h0, par_out}, {8'h0, (f >= 3) ? ex[f % 3] : ~ex[f % 3]});
    end
  endtask
  task automatic s_fault;
    for (int e = 0; e < 3; e++) begin
      apb(1'h1, `SHLP_ADDR_CTRL, 32'h10 + 32'(e) * 32'h20);
      pos_fault <= 1'h1;
      mv(20'h00007);
      cmp({8'h0, par_out}, e == 0 ? 32'h0 : e == 1 ? 32'hFFFFFF : 32'h1E240);
      pos_fault <= 1'h0;
      mv(20'h1E240);
    end
  endtask
  task automatic s_latch;
    apb(1'h1, `SHLP_ADDR_CTRL, 32'h10);
    hold <= 1'h1;
    cyc(8);
    mv(20'h00007);
    cmp({8'h0, par_out}, 32'h1E240);
    hold <= 1'h0;
    cyc(6);
    cmp({8'h0, par_out}, 32'h7);
  endtask
  task automatic s_sync;
    int n;
    apb(1'h1, `SHLP_ADDR_CTRL, 32'h18);
    mv(20'h00009);
    cyc(30);
    cmp({8'h0, par_out}, 32'h7);
    run <= 1'h1;
    n = 0;
    while (par_out !== 24'h9 && n < 200) begin
      cyc(1);
      n++;
    end
    if (n >= 200) begin
      miscompares++;
      wrap_up();
    end
    cyc(20);
    cmp({8'h0, par_out}, 32'h9);
    cmp({8'h0, seen}, 32'h9);
    run <= 1'h0;
    cyc(20);
    apb(1'h1, `SHLP_ADDR_CTRL, 32'h10);
  endtask
  // Two channels, one voltage and one current
  task automatic s_ana;
    logic [7:0] wa [9] = '{8'h10, 8'h08, 8'h14, 8'h0C, 8'h18, 8'h28, 8'h24, 8'h2C, 8'h30};
    logic [31:0] wd [9] = '{32'h0, 32'h1F4, 32'h7D0, 32'h7D0, 32'h2EE0, 32'h1, 32'h3E8, 32'hFFFFFFFB, 32'h7530};
    logic [19:0] ps [3] = '{20'h00190, 20'h004E2, 20'h009C4};
    logic [15:0] e1 [3] = '{16'h07D0, 16'h1388, 16'h1F40};
    logic [15:0] e2 [3] = '{16'h1F40, 16'h4E20, 16'h4E20};
    int n;
    for (int i = 0; i < 9; i++) apb(1'h1, wa[i], wd[i]);
    rdc(8'h18, 32'h2710);
    rdc(8'h2C, 32'h0);
    rdc(8'h30, 32'h4E20);
    apb(1'h1, 8'h18, 32'h1F40);
    for (int i = 0; i < 3; i++) begin
      mv(ps[i]);
      n = 0;
      while (ana_val_ch1 !== e1[i] && n < 64) begin
        cyc(1);
        n++;
      end
      if (n >= 64) begin
        miscompares++;
        wrap_up();
      end
      cmp({15'h0, ana_cur_ch1, ana_val_ch1}, {16'h0, e1[i]});
      cmp({15'h0, ana_cur_ch2, ana_val_ch2}, {16'h1, e2[i]});
    end
  endtask
  // Main sequence
  initial begin
    nrst = 1'h0;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 8'h0;
    pwdata = 32'h0;
    pos_in = 20'h00BB8;
    pos_fault = 1'h0;
    run = 1'h0;
    hold = 1'h0;
    repeat (3) @(posedge sys_clk);
    nrst <= 1'h1;
    cyc(3);
    s_regs();
    s_relay();
    s_ovr();
    s_fmt();
    s_fault();
    s_latch();
    s_sync();
    s_ana();
    wrap_up();
  end
endmodule // test_shut_height_limit_and_position_output
